// ---- verilog/sea_engine.v ----
// Script engine arithmetic unit with host and engine command merge
//
// Functional notes
// - Command bit active if host or engine drives
// - Analog command word takes most recent write
// - Each dout_out bit owned by engine or host only
// - Engine outputs commit at sweep end, last wins
// - Signed 32-bit datapath, limited 64-bit support
// - Add, sub, mul, div, remainder, absolute value
// - Add overflow loads status 0095, continues
// - Subtract overflow loads status 0095, continues
// - Multiply gives full 64-bit product, no overflow
// - Narrow destination keeps low product word
// - Remainder takes 32 or 64-bit numerator
// - Zero divisor 2093, divide overflow 2094
// - Divide overflow when quotient exceeds signed 32 bits
// - Divide fault aborts script, zeroes velocity
// - Absolute value; most negative operand gives 0096
// - Leaving run or enable clears engine command and output bits; aq_out holds
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sea_regs.vh"

module sea_engine
#(
  parameter NCMD  = 4,
  parameter NDOUT = 8
)
(
  clk_sys,
  rst_b,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  op_start,
  op_code,
  op_a,
  op_b,
  op_num64,
  op_wide,
  sweep_end,
  eng_cmd_wr,
  eng_cmd,
  eng_aq_wr,
  eng_aq,
  eng_dout_wr,
  eng_dout,
  res_word,
  res_dbl,
  res_valid,
  alu_busy,
  script_run,
  cmd_out,
  aq_out,
  dout_out,
  vel_zero,
  status_code
);
  input  wire                   clk_sys;
  input  wire                   rst_b;
  input  wire [`SEA_ADDR_W-1:0] reg_addr;
  input  wire [31:0]            reg_wdata;
  input  wire                   reg_wr;
  input  wire                   reg_rd;
  output reg  [31:0]            reg_rdata;
  input  wire                   op_start;
  input  wire [2:0]             op_code;
  input  wire [31:0]            op_a;
  input  wire [31:0]            op_b;
  input  wire [63:0]            op_num64;
  input  wire                   op_wide;
  input  wire                   sweep_end;
  input  wire                   eng_cmd_wr;
  input  wire [NCMD-1:0]        eng_cmd;
  input  wire                   eng_aq_wr;
  input  wire [31:0]            eng_aq;
  input  wire                   eng_dout_wr;
  input  wire [NDOUT-1:0]       eng_dout;
  output reg  [31:0]            res_word;
  output reg  [63:0]            res_dbl;
  output reg                    res_valid;
  output reg                    alu_busy;
  output reg                    script_run;
  output reg  [NCMD-1:0]        cmd_out;
  output reg  [31:0]            aq_out;
  output reg  [NDOUT-1:0]       dout_out;
  output reg                    vel_zero;
  output reg  [15:0]            status_code;

  // Software-visible state
  reg              en_reg;
  reg              run_reg;
  reg [NCMD-1:0]   host_cmd_reg;
  reg [NDOUT-1:0]  dout_sel_reg;
  reg [NDOUT-1:0]  host_dout_reg;
  reg              abort_reg;
  // Engine writes staged during a sweep, and the committed copies
  reg [NCMD-1:0]   stg_cmd_reg;
  reg [31:0]       stg_aq_reg;
  reg              stg_aq_set_reg;
  reg [NDOUT-1:0]  stg_dout_reg;
  reg [NCMD-1:0]   eng_cmd_reg;
  reg [NDOUT-1:0]  eng_dout_reg;
  // Operation in flight through the divider
  reg              div_mod_reg;

  reg  [15:0]      status_next;
  reg  [NDOUT-1:0] dout_next;
  wire             running;
  wire             host_aq_wr;
  wire             commit;
  wire             op_go;
  wire [32:0]      sum;
  wire [32:0]      diff;
  wire [63:0]      prod;
  wire [63:0]      div_num;
  wire             div_start;
  wire             div_busy;
  wire             div_done;
  wire             div_zero;
  wire             div_ovf;
  wire [31:0]      div_quot;
  wire [31:0]      div_rem;
  wire             div_fault;
  wire [NCMD-1:0]  cmd_next;
  genvar           g;

  assign running    = en_reg & run_reg & ~abort_reg;
  assign host_aq_wr = reg_wr && (reg_addr == `SEA_OFF_HOST_AQ);
  assign commit     = sweep_end & running;
  assign op_go      = op_start & running & ~alu_busy;

  // Sign-extended sums catch overflow in the top two bits
  assign sum  = {op_a[31], op_a} + {op_b[31], op_b};
  assign diff = {op_a[31], op_a} - {op_b[31], op_b};
  assign prod = $signed(op_a) * $signed(op_b);

  // Remainder and divide may take a 64-bit numerator
  assign div_num   = op_wide ? op_num64 : {{32{op_a[31]}}, op_a};
  assign div_start = op_go &&
                     (op_code == `SEA_OP_DIV || op_code == `SEA_OP_MOD);
  assign div_fault = div_done & (div_zero | div_ovf);

  sea_div u_div
  (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .start    (div_start),
    .num      (div_num),
    .den      (op_b),
    .busy     (div_busy),
    .done     (div_done),
    .div_zero (div_zero),
    .div_ovf  (div_ovf),
    .quot     (div_quot),
    .rem      (div_rem)
  );

  // Host and engine command bits are merged by OR
  assign cmd_next = running ? (host_cmd_reg | eng_cmd_reg) : host_cmd_reg;

  // Each faceplate output follows its one configured owner
  generate
    for (g = 0; g < NDOUT; g = g + 1)
    begin : g_dout
      always @*
      begin
        if (dout_sel_reg[g])
          dout_next[g] = running & eng_dout_reg[g];
        else
          dout_next[g] = host_dout_reg[g];
      end
    end
  endgenerate

  // Status word: hardware load wins over a software clear
  always @*
  begin
    status_next = status_code;
    if (reg_wr && reg_addr == `SEA_OFF_STATUS)
      status_next = reg_wdata[15:0];
    if (op_go && op_code == `SEA_OP_ADD && (sum[32] != sum[31]))
      status_next = `SEA_ST_ADD_OVF;
    if (op_go && op_code == `SEA_OP_SUB && (diff[32] != diff[31]))
      status_next = `SEA_ST_ADD_OVF;
    if (op_go && op_code == `SEA_OP_ABS && op_a == `SEA_INT_MIN)
      status_next = `SEA_ST_ABS_OVF;
    if (div_done && div_zero)
      status_next = `SEA_ST_DIV_ZERO;
    else if (div_done && div_ovf)
      status_next = `SEA_ST_DIV_OVF;
  end

  // Control registers and the abort latch
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      en_reg        <= 1'b0;
      run_reg       <= 1'b0;
      host_cmd_reg  <= {NCMD{1'b0}};
      dout_sel_reg  <= {NDOUT{1'b0}};
      host_dout_reg <= {NDOUT{1'b0}};
      abort_reg     <= 1'b0;
      status_code   <= `SEA_ST_NONE;
    end
    else
    begin
      status_code <= status_next;
      if (reg_wr)
      begin
        case (reg_addr)
          `SEA_OFF_CTRL:
          begin
            en_reg  <= reg_wdata[`SEA_CTRL_EN_BIT];
            run_reg <= reg_wdata[`SEA_CTRL_RUN_BIT];
          end
          `SEA_OFF_HOST_CMD:  host_cmd_reg  <= reg_wdata[NCMD-1:0];
          `SEA_OFF_DOUT_SEL:  dout_sel_reg  <= reg_wdata[NDOUT-1:0];
          `SEA_OFF_HOST_DOUT: host_dout_reg <= reg_wdata[NDOUT-1:0];
          default:            ;
        endcase
      end
      // Fault latches until enable is dropped, then a fresh start is allowed
      if (div_fault)
        abort_reg <= 1'b1;
      else if (!en_reg)
        abort_reg <= 1'b0;
    end
  end

  // Staging of engine writes; only the last write of a sweep lands
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      stg_cmd_reg    <= {NCMD{1'b0}};
      stg_aq_reg     <= 32'h0;
      stg_aq_set_reg <= 1'b0;
      stg_dout_reg   <= {NDOUT{1'b0}};
      eng_cmd_reg    <= {NCMD{1'b0}};
      eng_dout_reg   <= {NDOUT{1'b0}};
    end
    else if (!running)
    begin
      // Engine stopped: drop staged writes and its command and output bits; aq_out holds
      stg_cmd_reg    <= {NCMD{1'b0}};
      stg_aq_set_reg <= 1'b0;
      stg_dout_reg   <= {NDOUT{1'b0}};
      eng_cmd_reg    <= {NCMD{1'b0}};
      eng_dout_reg   <= {NDOUT{1'b0}};
    end
    else
    begin
      if (eng_cmd_wr)
        stg_cmd_reg <= eng_cmd;
      if (eng_dout_wr)
        stg_dout_reg <= eng_dout;
      if (eng_aq_wr)
        stg_aq_reg <= eng_aq;
      if (commit)
      begin
        eng_cmd_reg    <= eng_cmd_wr ? eng_cmd : stg_cmd_reg;
        eng_dout_reg   <= eng_dout_wr ? eng_dout : stg_dout_reg;
        stg_aq_set_reg <= 1'b0;
      end
      else if (eng_aq_wr)
        stg_aq_set_reg <= 1'b1;
    end
  end

  // Merged outputs, all registered
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cmd_out    <= {NCMD{1'b0}};
      dout_out   <= {NDOUT{1'b0}};
      aq_out     <= 32'h0;
      vel_zero   <= 1'b0;
      script_run <= 1'b0;
    end
    else
    begin
      cmd_out    <= cmd_next;
      dout_out   <= dout_next;
      script_run <= running;
      vel_zero   <= abort_reg | div_fault;
      // Last writer wins; an engine commit beats a host write
      if (commit && (stg_aq_set_reg || eng_aq_wr))
        aq_out <= eng_aq_wr ? eng_aq : stg_aq_reg;
      else if (host_aq_wr)
        aq_out <= reg_wdata;
    end
  end

  // Arithmetic results
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      res_word    <= 32'h0;
      res_dbl     <= 64'h0;
      res_valid   <= 1'b0;
      alu_busy    <= 1'b0;
      div_mod_reg <= 1'b0;
    end
    else
    begin
      res_valid <= 1'b0;
      if (op_go)
      begin
        case (op_code)
          `SEA_OP_ADD:
          begin
            res_word  <= sum[31:0];
            res_dbl   <= {{32{sum[31]}}, sum[31:0]};
            res_valid <= 1'b1;
          end
          `SEA_OP_SUB:
          begin
            res_word  <= diff[31:0];
            res_dbl   <= {{32{diff[31]}}, diff[31:0]};
            res_valid <= 1'b1;
          end
          `SEA_OP_MUL:
          begin
            res_word  <= prod[31:0];
            res_dbl   <= prod;
            res_valid <= 1'b1;
          end
          `SEA_OP_ABS:
          begin
            // Magnitude of the most negative value reads as 80000000
            res_word  <= op_a[31] ? (~op_a + 32'h1) : op_a;
            res_dbl   <= {32'h0, op_a[31] ? (~op_a + 32'h1) : op_a};
            res_valid <= 1'b1;
          end
          `SEA_OP_DIV,
          `SEA_OP_MOD:
          begin
            alu_busy    <= 1'b1;
            div_mod_reg <= (op_code == `SEA_OP_MOD);
          end
          default:
          begin
            res_valid <= 1'b0;
          end
        endcase
      end
      else if (div_done)
      begin
        alu_busy <= 1'b0;
        if (!div_zero && !div_ovf)
        begin
          res_word  <= div_mod_reg ? div_rem : div_quot;
          res_dbl   <= div_mod_reg ? {{32{div_rem[31]}}, div_rem}
                                   : {{32{div_quot[31]}}, div_quot};
          res_valid <= 1'b1;
        end
      end
    end
  end

  // Register read port, data in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SEA_OFF_CTRL:      reg_rdata <= {30'h0, run_reg, en_reg};
        `SEA_OFF_HOST_CMD:  reg_rdata <= {{(32-NCMD){1'b0}}, host_cmd_reg};
        `SEA_OFF_HOST_AQ:   reg_rdata <= aq_out;
        `SEA_OFF_DOUT_SEL:  reg_rdata <= {{(32-NDOUT){1'b0}}, dout_sel_reg};
        `SEA_OFF_HOST_DOUT: reg_rdata <= {{(32-NDOUT){1'b0}}, host_dout_reg};
        `SEA_OFF_STATUS:    reg_rdata <= {16'h0, status_code};
        `SEA_OFF_STATE:
          reg_rdata <= {28'h0, div_busy, alu_busy, abort_reg, running};
        default:            reg_rdata <= 32'h0;
      endcase
    end
    else
      reg_rdata <= 32'h0;
  end
endmodule

// ---- verilog/sea_regs.vh ----
// Register map, status codes, opcodes and counts of the script engine ALU
`ifndef SEA_REGS_VH
`define SEA_REGS_VH

`define SEA_ADDR_W        8
`define SEA_OFF_CTRL      8'h00
`define SEA_OFF_HOST_CMD  8'h04
`define SEA_OFF_HOST_AQ   8'h08
`define SEA_OFF_DOUT_SEL  8'h0c
`define SEA_OFF_HOST_DOUT 8'h10
`define SEA_OFF_STATUS    8'h14
`define SEA_OFF_STATE     8'h18

`define SEA_CTRL_EN_BIT   0
`define SEA_CTRL_RUN_BIT  1

`define SEA_ST_NONE       16'h0000
`define SEA_ST_ADD_OVF    16'h0095
`define SEA_ST_ABS_OVF    16'h0096
`define SEA_ST_DIV_ZERO   16'h2093
`define SEA_ST_DIV_OVF    16'h2094

`define SEA_OP_ADD        3'h0
`define SEA_OP_SUB        3'h1
`define SEA_OP_MUL        3'h2
`define SEA_OP_DIV        3'h3
`define SEA_OP_MOD        3'h4
`define SEA_OP_ABS        3'h5

`define SEA_DIV_STEPS     7'h40
`define SEA_INT_MIN       32'h80000000

`endif

// ---- verilog/sea_div.v ----
// Iterative signed 64/32 divider with truncation toward zero
`timescale 1ns/1ps
`include "sea_regs.vh"

module sea_div
(
  clk_sys,
  rst_b,
  start,
  num,
  den,
  busy,
  done,
  div_zero,
  div_ovf,
  quot,
  rem
);
  input  wire        clk_sys;
  input  wire        rst_b;
  input  wire        start;
  input  wire [63:0] num;
  input  wire [31:0] den;
  output reg         busy;
  output reg         done;
  output reg         div_zero;
  output reg         div_ovf;
  output reg  [31:0] quot;
  output reg  [31:0] rem;

  reg  [63:0] q_reg;
  reg  [32:0] r_reg;
  reg  [31:0] d_reg;
  reg  [6:0]  cnt_reg;
  reg         neg_q_reg;
  reg         neg_r_reg;
  wire [32:0] shifted;
  wire        fits;
  wire [63:0] nmag;
  wire [31:0] dmag;

  assign nmag    = num[63] ? (~num + 64'h1) : num;
  assign dmag    = den[31] ? (~den + 32'h1) : den;
  assign shifted = {r_reg[31:0], q_reg[63]};
  assign fits    = (shifted >= {1'b0, d_reg});

  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      busy      <= 1'b0;
      done      <= 1'b0;
      div_zero  <= 1'b0;
      div_ovf   <= 1'b0;
      quot      <= 32'h0;
      rem       <= 32'h0;
      q_reg     <= 64'h0;
      r_reg     <= 33'h0;
      d_reg     <= 32'h0;
      cnt_reg   <= 7'h0;
      neg_q_reg <= 1'b0;
      neg_r_reg <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        div_ovf <= 1'b0;
        if (den == 32'h0)
        begin
          div_zero <= 1'b1;
          done     <= 1'b1;
        end
        else
        begin
          div_zero  <= 1'b0;
          busy      <= 1'b1;
          q_reg     <= nmag;
          r_reg     <= 33'h0;
          d_reg     <= dmag;
          cnt_reg   <= `SEA_DIV_STEPS;
          neg_q_reg <= num[63] ^ den[31];
          neg_r_reg <= num[63];
        end
      end
      else if (busy)
      begin
        if (cnt_reg != 7'h0)
        begin
          r_reg   <= fits ? (shifted - {1'b0, d_reg}) : shifted;
          q_reg   <= {q_reg[62:0], fits};
          cnt_reg <= cnt_reg - 7'h1;
        end
        else
        begin
          // Quotient must fit in signed 32 bits
          div_ovf <= neg_q_reg ? (q_reg > 64'h0000000080000000)
                               : (q_reg > 64'h000000007fffffff);
          // Truncate toward zero, remainder takes numerator sign
          quot    <= neg_q_reg ? (~q_reg[31:0] + 32'h1) : q_reg[31:0];
          rem     <= neg_r_reg ? (~r_reg[31:0] + 32'h1) : r_reg[31:0];
          busy    <= 1'b0;
          done    <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- verification/sea_engine_asserts.sv ----
// Port assertions for the script engine ALU and command merge
`timescale 1ns/1ps
`include "sea_regs.vh"
module sea_engine_asserts
#(
  parameter NCMD  = 4,
  parameter NDOUT = 8
)
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        op_start,
  input wire logic [2:0]  op_code,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic        op_wide,
  input wire logic        sweep_end,
  input wire logic [31:0] res_word,
  input wire logic [63:0] res_dbl,
  input wire logic        res_valid,
  input wire logic        alu_busy,
  input wire logic        script_run,
  input wire logic [31:0] aq_out,
  input wire logic        vel_zero,
  input wire logic [15:0] status_code
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  reg                ctl_q;
  // A control write or a fault stops the engine a cycle before script_run
  wire               acc = op_start && script_run && !alu_busy &&
                           !ctl_q && !vel_zero;
  wire               dv  = acc && (op_code == `SEA_OP_DIV ||
                                   op_code == `SEA_OP_MOD);
  wire        [32:0] sm  = {op_a[31], op_a} + {op_b[31], op_b};
  wire        [32:0] df  = {op_a[31], op_a} - {op_b[31], op_b};
  wire signed [63:0] pr  = $signed(op_a) * $signed(op_b);
  reg         [31:0] sm_q, df_q, dv_q, wd_q;
  reg         [63:0] pr_q;
  // Expected results held one cycle, quotient held until it lands
  always @(posedge clk_sys)
  begin
    sm_q <= sm[31:0];
    df_q <= df[31:0];
    pr_q <= pr;
    wd_q <= reg_wdata;
    ctl_q <= reg_wr && reg_addr == `SEA_OFF_CTRL;
    if (dv && op_b != 32'h0)
      dv_q <= (op_code == `SEA_OP_DIV) ? $signed(op_a) / $signed(op_b)
                                        : $signed(op_a) % $signed(op_b);
  end
  a_add_ovf_flag: assert property (
    acc && op_code == `SEA_OP_ADD && sm[32] != sm[31] |=> res_valid &&
    res_word == sm_q && status_code == `SEA_ST_ADD_OVF && script_run)
    else $error("add overflow not flagged");
  a_sub_ovf_flag: assert property (
    acc && op_code == `SEA_OP_SUB && df[32] != df[31] |=> res_valid &&
    res_word == df_q && status_code == `SEA_ST_ADD_OVF && script_run)
    else $error("subtract overflow not flagged");
  a_mul_full_product: assert property (
    acc && op_code == `SEA_OP_MUL |=> res_valid && res_dbl == pr_q &&
    res_word == pr_q[31:0])
    else $error("product wrong");
  a_abs_min_flag: assert property (
    acc && op_code == `SEA_OP_ABS && op_a == `SEA_INT_MIN |=> res_valid &&
    res_word == 32'h80000000 && status_code == `SEA_ST_ABS_OVF && script_run)
    else $error("abs of minimum not flagged");
  a_div_zero_abort: assert property (
    dv && op_b == 32'h0 |-> ##2 status_code == `SEA_ST_DIV_ZERO &&
    vel_zero && !res_valid ##1 !script_run)
    else $error("zero divisor not aborted");
  a_div_result_time: assert property (
    dv && op_b != 32'h0 && !op_wide &&
    !(op_a == `SEA_INT_MIN && op_b == 32'hffffffff)
    |=> alu_busy ##66 res_valid && res_word == dv_q)
    else $error("quotient or remainder wrong");
  a_read_idle_zero: assert property (
    $past(reg_rd) == 1'b0 |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_host_aq_last: assert property (
    reg_wr && reg_addr == `SEA_OFF_HOST_AQ && !sweep_end &&
    !$past(sweep_end) |=> aq_out == wd_q)
    else $error("host analog word not applied");
  a_fault_stops_run: assert property (
    $rose(vel_zero) |=> !script_run && !res_valid)
    else $error("fault did not stop engine");
endmodule
bind sea_engine sea_engine_asserts #(.NCMD(NCMD), .NDOUT(NDOUT)) u_chk (.*);

// ---- verification/sea_host_model.sv ----
// Host controller model driving the register port
`timescale 1ns/1ps
module sea_host_model
(
  input  wire logic        clk_sys,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released write data is inverted so stale values cannot pass
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the script engine ALU and command merge
`timescale 1ns/1ps
`include "sea_regs.vh"
module tb_top;
  reg         clk_sys = 1'b0;
  reg         rst_b = 1'b0;
  reg         op_start = 1'b0;
  reg  [2:0]  op_code = 3'h0;
  reg  [31:0] op_a = 32'h0;
  reg  [31:0] op_b = 32'h0;
  reg  [63:0] op_num64 = 64'h0;
  reg         op_wide = 1'b0;
  reg         sweep_end = 1'b0;
  reg         eng_cmd_wr = 1'b0;
  reg  [3:0]  eng_cmd = 4'h0;
  reg         eng_aq_wr = 1'b0;
  reg  [31:0] eng_aq = 32'h0;
  reg         eng_dout_wr = 1'b0;
  reg  [7:0]  eng_dout = 8'h0;
  wire [7:0]  reg_addr, dout_out;
  wire [31:0] reg_wdata, reg_rdata, res_word, aq_out;
  wire [63:0] res_dbl;
  wire        reg_wr, reg_rd, res_valid, alu_busy, script_run, vel_zero;
  wire [3:0]  cmd_out;
  wire [15:0] status_code;
  int         error_cnt = 0;
  int         n_tests = 0;
  logic [31:0] seed = 32'h38;
  logic [31:0] a, b, d, r, la, lc;
  logic [63:0] n, q;
  logic [2:0]  c;
  logic [3:0]  ec = 4'h2;
  logic [66:0] tbl [12] = '{
    {`SEA_OP_ADD, 32'h7fffffff, 32'h1},
    {`SEA_OP_ADD, 32'h80000000, 32'hffffffff},
    {`SEA_OP_SUB, 32'h80000000, 32'h1},
    {`SEA_OP_SUB, 32'h0, 32'h80000000},
    {`SEA_OP_SUB, 32'h7fffffff, 32'hffffffff},
    {`SEA_OP_MUL, 32'h7fffffff, 32'h7fffffff},
    {`SEA_OP_MUL, 32'h80000000, 32'h80000000},
    {`SEA_OP_ABS, 32'h80000000, 32'h0},
    {`SEA_OP_ABS, 32'hffffff85, 32'h0},
    {`SEA_OP_DIV, 32'hfffffff9, 32'h2},
    {`SEA_OP_MOD, 32'hfffffff9, 32'h2},
    {`SEA_OP_MOD, 32'h7, 32'hfffffffe}};
  sea_engine #(.NCMD(4), .NDOUT(8)) DUT (.*);
  sea_host_model host (.*);
  always #4 clk_sys = ~clk_sys;
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [63:0] calc(input logic [2:0] c, input logic [31:0] a, b);
    case (c)
      `SEA_OP_ADD: calc = {32'h0, a + b};
      `SEA_OP_SUB: calc = {32'h0, a - b};
      `SEA_OP_MUL: calc = $signed(a) * $signed(b);
      `SEA_OP_DIV: calc = {32'h0, $signed(a) / $signed(b)};
      `SEA_OP_MOD: calc = {32'h0, $signed(a) % $signed(b)};
      default: calc = {32'h0, a[31] ? -a : a};
    endcase
  endfunction
  function logic [15:0] st_exp(input logic [2:0] c, input logic [31:0] a, b);
    logic [31:0] s;
    logic [31:0] t;
    s = a + b;
    t = a - b;
    st_exp = `SEA_ST_NONE;
    if (c == `SEA_OP_ADD && a[31] == b[31] && s[31] != a[31])
      st_exp = `SEA_ST_ADD_OVF;
    if (c == `SEA_OP_SUB && a[31] != b[31] && t[31] != a[31])
      st_exp = `SEA_ST_ADD_OVF;
    if (c == `SEA_OP_ABS && a == `SEA_INT_MIN)
      st_exp = `SEA_ST_ABS_OVF;
  endfunction
  task print_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task op(input logic [2:0] c, input logic [31:0] a, b, input logic w,
          input logic [63:0] n);
    int k;
    @(posedge clk_sys);
    op_start <= 1'b1;
    op_code <= c;
    op_a <= a;
    op_b <= b;
    op_wide <= w;
    op_num64 <= n;
    @(posedge clk_sys);
    op_start <= 1'b0;
    #1;
    for (k = 0; k < 100 && res_valid !== 1'b1 && vel_zero !== 1'b1; k++)
      @(posedge clk_sys) #1;
    if (k == 100)
    begin
      error_cnt++;
      print_verdict;
    end
  endtask
  task alu(input logic [2:0] c, input logic [31:0] a, b);
    host.wr(`SEA_OFF_STATUS, 32'h0);
    op(c, a, b, 1'b0, 64'h0);
    chk("res_word", res_word, calc(c, a, b) & 64'hffffffff);
    if (c == `SEA_OP_MUL)
      chk("res_dbl", res_dbl, calc(c, a, b));
    chk("status", status_code, st_exp(c, a, b));
  endtask
  // Longer sweeps leave the closing cycle silent, so the staged copy lands
  task sweep(input int m);
    logic w;
    for (int k = 0; k < m; k++)
    begin
      @(posedge clk_sys);
      w = (k < m - 1) || (m == 1);
      if (w)
      begin
        lc = xs();
        la = xs();
      end
      eng_cmd_wr <= w;
      eng_cmd <= lc[3:0];
      eng_dout_wr <= w;
      eng_dout <= lc[11:4];
      eng_aq_wr <= w;
      eng_aq <= la;
      sweep_end <= (k == m - 1);
    end
    @(posedge clk_sys);
    eng_cmd_wr <= 1'b0;
    eng_dout_wr <= 1'b0;
    eng_aq_wr <= 1'b0;
    sweep_end <= 1'b0;
    #1;
  endtask
  task restart;
    host.wr(`SEA_OFF_CTRL, 32'h0);
    host.wr(`SEA_OFF_CTRL, 32'h3);
    host.wr(`SEA_OFF_STATUS, 32'h0);
    repeat (2) @(posedge clk_sys);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk("reset", {script_run, vel_zero, res_valid, cmd_out}, 64'h0);
    chk("reset_status", status_code, 64'h0);
    host.rd(8'h40, d);
    chk("unmapped", d, 32'h0);
    host.wr(`SEA_OFF_HOST_CMD, 32'h2);
    host.wr(`SEA_OFF_DOUT_SEL, 32'hf0);
    host.wr(`SEA_OFF_HOST_DOUT, 32'h5a);
    restart;
    chk("run", script_run, 1'b1);
    foreach (tbl[i])
      alu(tbl[i][66:64], tbl[i][63:32], tbl[i][31:0]);
    for (int i = 0; i < 40; i++)
    begin
      c = 3'(xs() % 6);
      a = xs();
      b = xs();
      if (c == `SEA_OP_DIV || c == `SEA_OP_MOD)
        b = b | 32'h1;
      if (a == `SEA_INT_MIN)
        a = 32'h0;
      alu(c, a, b);
    end
    for (int i = 0; i < 4; i++)
    begin
      n = $signed(xs()) * 3;
      b = xs() | 32'h10;
      q = $signed(n) % $signed(b);
      op(`SEA_OP_MOD, 32'h0, b, 1'b1, n);
      chk("wide", res_word, q[31:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      if (i[0])
      begin
        d = xs();
        host.wr(`SEA_OFF_HOST_AQ, d);
        host.rd(`SEA_OFF_HOST_AQ, r);
        chk("aq_host", r, d);
      end
      sweep(1 + xs() % 4);
      chk("cmd_hold", cmd_out, ec);
      ec = 4'h2 | lc[3:0];
      repeat (2) @(posedge clk_sys) #1;
      chk("cmd_out", cmd_out, ec);
      chk("dout_out", dout_out, (lc[11:4] & 8'hf0) | 8'h0a);
      chk("aq_out", aq_out, la);
    end
    host.wr(`SEA_OFF_CTRL, 32'h1);
    sweep(2);
    @(posedge clk_sys);
    op_start <= 1'b1;
    op_code <= `SEA_OP_ADD;
    @(posedge clk_sys);
    op_start <= 1'b0;
    #1;
    chk("refused", res_valid, 1'b0);
    repeat (2) @(posedge clk_sys) #1;
    chk("stop", {script_run, res_valid, cmd_out, dout_out}, 64'h20a);
    for (int i = 0; i < 3; i++)
    begin
      restart;
      op(i ? `SEA_OP_MOD : `SEA_OP_DIV, 32'h5, i == 2, i == 2, 64'h100000000);
      d = i == 2 ? `SEA_ST_DIV_OVF : `SEA_ST_DIV_ZERO;
      chk("fault", status_code, d);
      chk("vel_zero", vel_zero, 1'b1);
      repeat (2) @(posedge clk_sys) #1;
      chk("abort", {script_run, cmd_out}, 64'h2);
      host.rd(`SEA_OFF_STATE, d);
      chk("state", d, 32'h2);
    end
    print_verdict;
  end
endmodule
